// ==== shared/nic_pkg.sv ====
package nic_pkg;

    // Register map: 2FH/3FH are not word multiples, so offsets are word indices
    localparam logic [7:0] NIC_IDX_PERMIT = 8'h2F;
    localparam logic [7:0] NIC_IDX_REQUEST = 8'h3F;
    localparam logic [7:0] NIC_IDX_GLOBAL = 8'h40;
    localparam logic [7:0] NIC_IDX_STATUS = 8'h41;
    localparam logic [7:0] NIC_IDX_EVT_STAT = 8'h42;
    localparam logic [7:0] NIC_IDX_EVT_CLR = 8'h43;
    localparam logic [7:0] NIC_IDX_EVT_EN = 8'h44;

    // Source bit positions
    localparam int NIC_SRC_PIN = 0;
    localparam int NIC_SRC_TMR = 1;
    localparam int NIC_SRC_VSY = 2;
    localparam int NIC_SRC_SIO = 3;
    localparam int NIC_NSRC = 4;

    localparam int NIC_RSTACK_DEPTH = 6;
    localparam int NIC_ISTACK_DEPTH = 2;
    localparam int NIC_ADDR_W = 12;
    localparam int NIC_BANK_W = 2;

    localparam logic [3:0] NIC_PERMIT_RST = 4'h0;
    localparam logic [3:0] NIC_REQUEST_RST = 4'h0;
    localparam logic [NIC_BANK_W-1:0] NIC_BANK_ZERO = 2'h0;

    // Event status bits
    localparam int NIC_EV_ACCEPT = 0;
    localparam int NIC_EV_OVERFLOW = 1;
    localparam int NIC_EV_CTX_LOST = 2;
    localparam int NIC_NEV = 3;

    typedef struct packed {
        logic [NIC_BANK_W-1:0] bank;
        logic index_enable_flag;
    } nic_ctx_t;

    // CPU-side request/answer group
    typedef struct packed {
        logic call;
        logic ret;
        logic return_from_service_instr;
        logic global_irq_enable_instr;
        logic global_irq_disable_instr;
        logic [NIC_ADDR_W-1:0] push_addr;
        nic_ctx_t cur_ctx;
    } nic_cpu_req_t;

    typedef struct packed {
        logic take_irq;
        logic [1:0] vector;
        logic [NIC_ADDR_W-1:0] pop_addr;
        logic restore;
        nic_ctx_t ctx;
    } nic_cpu_ans_t;

endpackage : nic_pkg

// ==== hw/nic_core.sv ====
`timescale 1ns/1ps
//
// Contract
// - Accepting an interrupt pushes its return address onto the return stack.
// - The return stack holds six entries, levels 0 to 5.
// - Calls and interrupts share that one return stack.
// - Accepting an interrupt selects data bank 0 before the service routine starts.
// - Exactly four sources exist: filtered pin, timer, vertical sync, serial.
// - At three nested levels the oldest context is swept off, so the final return restores the second one's again.
// - The global enable instruction opens every source whose permit flag is set.
// - The per-source permit flags form the register at index 2FH.
// - The per-source request flags form the register at index 3FH.
// - The timer request comes from the interval pulse of the second selector.
// - The context stack is two deep, saving bank and index enable, which are then cleared.
module nic_core
    import nic_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic filtered_irq_pin,
    input wire logic vsync_pin,
    input wire logic pin_edge_fall,
    input wire logic vsync_edge_fall,
    input wire logic timer_interval_pulse,
    input wire logic serial_done_pulse,
    input wire nic_pkg::nic_cpu_req_t cpu_req,
    output nic_pkg::nic_cpu_ans_t cpu_ans,
    output logic irq
);
    import nic_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // All state lives here so one register process covers reset and the clock enable
    typedef struct packed {
        logic [1:0] pin_sync;
        logic [1:0] vsy_sync;
        logic pin_last;
        logic vsy_last;
        logic [NIC_NSRC-1:0] permit;
        logic [NIC_NSRC-1:0] request;
        logic gie;
        logic [NIC_RSTACK_DEPTH-1:0][NIC_ADDR_W-1:0] rstack;
        logic [2:0] rdepth;
        nic_ctx_t [NIC_ISTACK_DEPTH-1:0] istack;
        // Live contexts, saturating at the stack depth; only used to flag a sweep-off
        logic [1:0] ilevel;
        logic [NIC_NEV-1:0] ev_stat;
        logic [NIC_NEV-1:0] ev_en;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        nic_cpu_ans_t ans;
        logic irq;
    } nic_state_t;

    nic_state_t st_ff;
    nic_state_t nxt_st;

    ////////////////////////////////////////////////////////////////////////////////
    // Word index decode, shared by read and write paths
    function automatic logic idx_hit(input logic [31:0] a, input logic [7:0] idx);
        idx_hit = (a[1:0] == 2'h0) && (a[31:2] == {22'h0, idx});
    endfunction : idx_hit

    function automatic logic mapped(input logic [31:0] a);
        mapped = idx_hit(a, NIC_IDX_PERMIT) || idx_hit(a, NIC_IDX_REQUEST) ||
                 idx_hit(a, NIC_IDX_GLOBAL) || idx_hit(a, NIC_IDX_STATUS) ||
                 idx_hit(a, NIC_IDX_EVT_STAT) || idx_hit(a, NIC_IDX_EVT_CLR) ||
                 idx_hit(a, NIC_IDX_EVT_EN);
    endfunction : mapped

    // Shared by both pins; flipping the select while the pin is steady raises no edge by itself
    function automatic logic edge_seen(input logic fall, input logic last, input logic now);
        edge_seen = fall ? (last && !now) : (!last && now);
    endfunction : edge_seen

    logic access;
    logic wr;
    logic rd;
    logic pin_rise;
    logic vsy_rise;
    logic [NIC_NSRC-1:0] src_evt;
    logic [NIC_NSRC-1:0] pending;
    logic [1:0] winner;
    logic take;
    logic [NIC_NEV-1:0] ev_set;
    logic rstack_full;
    logic stack_op;

    // One fixed wait state: the request is decoded once and pready answers on the next edge
    assign access = psel && penable && !st_ff.pready;
    assign wr = access && pwrite;
    assign rd = access && !pwrite;

    ////////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        nxt_st = st_ff;
        ev_set = '0;
        nxt_st.ans.take_irq = 1'b0;
        nxt_st.ans.restore = 1'b0;
        nxt_st.pready = access;
        // Unmapped or unaligned words answer with an error and change nothing
        nxt_st.pslverr = access && !mapped(paddr);

        // Pins are asynchronous: two flops before any edge logic
        nxt_st.pin_sync = {st_ff.pin_sync[0], filtered_irq_pin};
        nxt_st.vsy_sync = {st_ff.vsy_sync[0], vsync_pin};
        nxt_st.pin_last = st_ff.pin_sync[1];
        nxt_st.vsy_last = st_ff.vsy_sync[1];
        pin_rise = edge_seen(pin_edge_fall, st_ff.pin_last, st_ff.pin_sync[1]);
        vsy_rise = edge_seen(vsync_edge_fall, st_ff.vsy_last, st_ff.vsy_sync[1]);

        src_evt = '0;
        src_evt[NIC_SRC_PIN] = pin_rise;
        src_evt[NIC_SRC_TMR] = timer_interval_pulse;
        src_evt[NIC_SRC_VSY] = vsy_rise;
        src_evt[NIC_SRC_SIO] = serial_done_pulse;

        // Fixed priority among simultaneous pending sources, lowest bit wins
        pending = st_ff.request & st_ff.permit;
        winner = 2'h0;
        for (int i = NIC_NSRC - 1; i >= 0; i--)
        begin
            if (pending[i])
            begin
                winner = i[1:0];
            end
        end
        // Depth six is full: an interrupt then waits rather than overwrite a return address
        rstack_full = (st_ff.rdepth >= 3'(NIC_RSTACK_DEPTH));
        stack_op = cpu_req.call || cpu_req.ret || cpu_req.return_from_service_instr;
        // Push needs a free return slot; a full stack holds the request pending
        take = st_ff.gie && (pending != '0) && !stack_op && !rstack_full;

        // Software write to request register; a new edge wins over a clear
        if (wr && idx_hit(paddr, NIC_IDX_REQUEST))
        begin
            nxt_st.request = pwdata[NIC_NSRC-1:0];
        end
        if (wr && idx_hit(paddr, NIC_IDX_PERMIT))
        begin
            nxt_st.permit = pwdata[NIC_NSRC-1:0];
        end
        if (wr && idx_hit(paddr, NIC_IDX_GLOBAL))
        begin
            nxt_st.gie = pwdata[0];
        end
        if (wr && idx_hit(paddr, NIC_IDX_EVT_EN))
        begin
            nxt_st.ev_en = pwdata[NIC_NEV-1:0];
        end
        if (wr && idx_hit(paddr, NIC_IDX_EVT_CLR))
        begin
            nxt_st.ev_stat = st_ff.ev_stat & ~pwdata[NIC_NEV-1:0];
        end

        // A disable in the same cycle as an enable wins, being applied last
        if (cpu_req.global_irq_enable_instr)
        begin
            nxt_st.gie = 1'b1;
        end
        if (cpu_req.global_irq_disable_instr)
        begin
            nxt_st.gie = 1'b0;
        end

        if (take)
        begin
            nxt_st.request[winner] = 1'b0;
            nxt_st.gie = 1'b0;
            nxt_st.rstack[st_ff.rdepth] = cpu_req.push_addr;
            nxt_st.rdepth = st_ff.rdepth + 3'h1;
            // Sweep-off: the older entry falls out when a third context arrives
            if (st_ff.ilevel == 2'(NIC_ISTACK_DEPTH))
            begin
                ev_set[NIC_EV_CTX_LOST] = 1'b1;
            end
            else
            begin
                nxt_st.ilevel = st_ff.ilevel + 2'h1;
            end
            nxt_st.istack[1] = st_ff.istack[0];
            nxt_st.istack[0] = cpu_req.cur_ctx;
            nxt_st.ans.take_irq = 1'b1;
            nxt_st.ans.vector = winner;
            // Service starts in bank 0 with indexing off
            nxt_st.ans.ctx.bank = NIC_BANK_ZERO;
            nxt_st.ans.ctx.index_enable_flag = 1'b0;
            ev_set[NIC_EV_ACCEPT] = 1'b1;
        end
        else if (cpu_req.call)
        begin
            if (!rstack_full)
            begin
                nxt_st.rstack[st_ff.rdepth] = cpu_req.push_addr;
                nxt_st.rdepth = st_ff.rdepth + 3'h1;
            end
            else
            begin
                // A call with no free slot is dropped and reported, never wrapped
                ev_set[NIC_EV_OVERFLOW] = 1'b1;
            end
        end
        else if (cpu_req.ret || cpu_req.return_from_service_instr)
        begin
            // An empty stack keeps depth zero and leaves the last address on the bus
            if (st_ff.rdepth != 3'h0)
            begin
                nxt_st.rdepth = st_ff.rdepth - 3'h1;
                nxt_st.ans.pop_addr = st_ff.rstack[st_ff.rdepth - 3'h1];
            end
            if (cpu_req.return_from_service_instr)
            begin
                nxt_st.ans.restore = 1'b1;
                nxt_st.ans.ctx = st_ff.istack[0];
                nxt_st.istack[0] = st_ff.istack[1];
                // Bottom entry stays, so unwinding past a swept-off level hands back the oldest survivor
                if (st_ff.ilevel != 2'h0)
                begin
                    nxt_st.ilevel = st_ff.ilevel - 2'h1;
                end
                nxt_st.gie = 1'b1;
            end
        end

        // Hardware events set after software writes, so set wins over clear
        for (int i = 0; i < NIC_NSRC; i++)
        begin
            if (src_evt[i])
            begin
                nxt_st.request[i] = 1'b1;
            end
        end
        nxt_st.ev_stat = nxt_st.ev_stat | ev_set;
        // Built from the registered enable, so irq follows enable writes one cycle late
        nxt_st.irq = (nxt_st.ev_stat & st_ff.ev_en) != '0;

        // Reads of write-only or unmapped words return zero
        nxt_st.prdata = st_ff.prdata;
        if (rd)
        begin
            nxt_st.prdata = 32'h0;
            if (idx_hit(paddr, NIC_IDX_PERMIT))
            begin
                nxt_st.prdata = {28'h0, st_ff.permit};
            end
            if (idx_hit(paddr, NIC_IDX_REQUEST))
            begin
                nxt_st.prdata = {28'h0, st_ff.request};
            end
            if (idx_hit(paddr, NIC_IDX_GLOBAL))
            begin
                nxt_st.prdata = {31'h0, st_ff.gie};
            end
            if (idx_hit(paddr, NIC_IDX_STATUS))
            begin
                nxt_st.prdata = {21'h0, st_ff.istack[1], st_ff.istack[0], st_ff.vsy_sync[1],
                                 st_ff.pin_sync[1], st_ff.rdepth};
            end
            if (idx_hit(paddr, NIC_IDX_EVT_STAT))
            begin
                nxt_st.prdata = {29'h0, st_ff.ev_stat};
            end
            if (idx_hit(paddr, NIC_IDX_EVT_EN))
            begin
                nxt_st.prdata = {29'h0, st_ff.ev_en};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_ff <= '0;
            // Nothing is permitted or pending until software opens a source
            st_ff.permit <= NIC_PERMIT_RST;
            st_ff.request <= NIC_REQUEST_RST;
        end
        else if (clk_en)
        begin
            st_ff <= nxt_st;
        end
    end

    assign prdata = st_ff.prdata;
    assign pready = st_ff.pready;
    assign pslverr = st_ff.pslverr;
    assign cpu_ans = st_ff.ans;
    assign irq = st_ff.irq;

endmodule : nic_core

// ==== verification/nic_cpu_model.sv ====
`timescale 1ns/1ps
module nic_cpu_model
    import nic_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [4:0] op,
    input wire logic [11:0] pc,
    input wire logic set_stb,
    input wire nic_pkg::nic_ctx_t set_ctx,
    input wire nic_pkg::nic_cpu_ans_t cpu_ans,
    output nic_pkg::nic_cpu_req_t cpu_req
);
    nic_ctx_t ctx_ff;
    // The core adopts whatever context the block hands back, so a bad restore shows up in later pushes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctx_ff <= '0;
        else if (cpu_ans.take_irq || cpu_ans.restore)
            ctx_ff <= cpu_ans.ctx;
        else if (set_stb)
            ctx_ff <= set_ctx;
    end
    assign cpu_req = {op, pc, ctx_ff};
endmodule : nic_cpu_model

// ==== verification/nic_asserts.sv ====
`timescale 1ns/1ps
module nic_asserts
    import nic_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire nic_pkg::nic_cpu_req_t cpu_req,
    input wire nic_pkg::nic_cpu_ans_t cpu_ans
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc = psel && penable && !pready && clk_en;
    a_one_wait: assert property (acc |=> pready) else $error("ready late");
    a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
    a_err_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
    a_unaligned_err: assert property (acc && paddr[1:0] != 2'h0 |=> pslverr) else $error("unaligned ok");
    a_permit_width: assert property (acc && !pwrite && paddr == 32'h0BC |=> prdata[31:4] == 28'h0)
        else $error("permit wide");
    a_take_bank0: assert property (cpu_ans.take_irq |-> cpu_ans.ctx == 3'h0) else $error("ctx kept");
    a_take_once: assert property (cpu_ans.take_irq |=> !cpu_ans.take_irq) else $error("take twice");
    a_take_excl: assert property (!(cpu_ans.take_irq && cpu_ans.restore)) else $error("take and restore");
    a_take_no_call: assert property (cpu_ans.take_irq |->
        !$past(cpu_req.call || cpu_req.ret || cpu_req.return_from_service_instr)) else $error("take beside call");
    c_take: cover property (cpu_ans.take_irq);
    c_restore: cover property (cpu_ans.restore);
    c_err: cover property (pslverr);
endmodule : nic_asserts
bind nic_core nic_asserts u_chk (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_req(cpu_req),
    .cpu_ans(cpu_ans));

// ==== verification/nested_interrupt_context_tb.sv ====
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin failures++; $display("mismatch %s %0h %0h", nm, e, g); end end
module nested_interrupt_context_tb;
    import nic_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, set_stb = 0;
    logic fpin = 0, vpin = 0, tmr = 0, sio = 0, cen = 1, fedge = 0;
    logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
    logic [4:0] op = '0;
    logic [11:0] pc = '0;
    nic_ctx_t set_ctx = '0;
    nic_cpu_req_t cpu_req;
    nic_cpu_ans_t cpu_ans;
    int failures = 0, n_compared = 0;
    localparam logic [4:0] OP_CALL = 5'h10, OP_RET = 5'h08, OP_SVC_RET = 5'h04, OP_GIE_ON = 5'h02;
    localparam logic [4:0] OP_GIE_OFF = 5'h01;
    always #20 pclk = ~pclk;
    nic_core DUT (.pclk(pclk), .presetn(presetn), .clk_en(cen), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .filtered_irq_pin(fpin), .vsync_pin(vpin), .pin_edge_fall(fedge), .vsync_edge_fall(1'b0),
        .timer_interval_pulse(tmr), .serial_done_pulse(sio), .cpu_req(cpu_req), .cpu_ans(cpu_ans), .irq(irq));
    nic_cpu_model u_cpu (.pclk(pclk), .presetn(presetn), .op(op), .pc(pc), .set_stb(set_stb),
        .set_ctx(set_ctx), .cpu_ans(cpu_ans), .cpu_req(cpu_req));
    ////////////////////////////////////////////////////////////////
    task final_report;
        if (failures == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : final_report
    task tmo;
        failures++;
        final_report();
    endtask : tmo
    task apb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic e);
        int i;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        if (i == 20)
            tmo();
        rd = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    task rchk(input logic [31:0] a, input logic [31:0] x);
        logic e;
        apb(1'b0, a, 32'h0, e);
        `CHK("prdata", x, rd)
    endtask : rchk
    task wr(input logic [31:0] a, input logic [31:0] d);
        logic e;
        apb(1'b1, a, d, e);
    endtask : wr
    // Sample one tick after the edge so the block's answer has landed
    task cpu(input logic [4:0] o, input logic [11:0] a);
        @(posedge pclk);
        {op, pc} <= {o, a};
        @(posedge pclk);
        op <= 5'h0;
        #1;
    endtask : cpu
    task trig(input int s);
        @(posedge pclk);
        {sio, vpin, tmr, fpin} <= 4'h1 << s;
        @(posedge pclk);
        {sio, vpin, tmr, fpin} <= 4'h0;
    endtask : trig
    task setctx(input nic_ctx_t c);
        @(posedge pclk);
        {set_stb, set_ctx} <= {1'b1, c};
        @(posedge pclk);
        set_stb <= 1'b0;
    endtask : setctx
    task take(input logic [1:0] v);
        int i;
        for (i = 0; i < 30; i++)
        begin
            @(posedge pclk);
            #1;
            if (cpu_ans.take_irq === 1'b1)
                break;
        end
        if (i == 30)
            tmo();
        `CHK("vector", v, cpu_ans.vector)
        `CHK("take_ctx", 3'h0, cpu_ans.ctx)
    endtask : take
    ////////////////////////////////////////////////////////////////
    initial
    begin
        logic e;
        int s;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rchk(32'h0BC, 32'h0);
        rchk(32'h0FC, 32'h0);
        apb(1'b0, 32'h200, 32'h0, e);
        `CHK("unmapped", 1'b1, e)
        wr(32'h0BC, 32'hF);
        rchk(32'h0BC, 32'hF);
        for (s = 0; s < 4; s++)
        begin
            trig(s);
            rchk(32'h0FC, 32'h1 << s);
            cpu(OP_GIE_ON, 12'h100 + 12'(s));
            take(2'(s));
            rchk(32'h0FC, 32'h0);
            cpu(OP_SVC_RET, 12'h0);
            `CHK("pop_addr", 12'h100 + 12'(s), cpu_ans.pop_addr)
            cpu(OP_GIE_OFF, 12'h0);
        end
        apb(1'b0, 32'h0BD, 32'h0, e);
        `CHK("unaligned", 1'b1, e)
        // Falling-edge select: the pin pulse is seen one cycle later, on its trailing edge
        fedge <= 1'b1;
        trig(0);
        @(posedge pclk);
        rchk(32'h0FC, 32'h1);
        wr(32'h0FC, 32'h0);
        // A timer pulse while the clock enable is low must leave no trace
        {fedge, cen} <= 2'b00;
        trig(1);
        cen <= 1'b1;
        rchk(32'h0FC, 32'h0);
        wr(32'h110, 32'h7);
        for (s = 0; s < 5; s++)
            cpu(OP_CALL, 12'h0A0 + 12'(s));
        trig(1);
        cpu(OP_GIE_ON, 12'h0B0);
        take(2'h1);
        cpu(OP_CALL, 12'h0C0);
        rchk(32'h108, 32'h3);
        `CHK("irq", 1'b1, irq)
        wr(32'h10C, 32'h7);
        rchk(32'h108, 32'h0);
        `CHK("irq", 1'b0, irq)
        cpu(OP_SVC_RET, 12'h0);
        `CHK("pop_addr", 12'h0B0, cpu_ans.pop_addr)
        for (s = 4; s >= 0; s--)
        begin
            cpu(OP_RET, 12'h0);
            `CHK("pop_addr", 12'h0A0 + 12'(s), cpu_ans.pop_addr)
        end
        cpu(OP_GIE_OFF, 12'h0);
        setctx(3'h7);
        trig(1);
        cpu(OP_GIE_ON, 12'h0D0);
        take(2'h1);
        setctx(3'h2);
        trig(3);
        cpu(OP_GIE_ON, 12'h0D1);
        take(2'h3);
        setctx(3'h5);
        trig(0);
        cpu(OP_GIE_ON, 12'h0D2);
        take(2'h0);
        rchk(32'h108, 32'h5);
        rchk(32'h104, 32'h2A3);
        rchk(32'h100, 32'h0);
        cpu(OP_SVC_RET, 12'h0);
        `CHK("ctx", 3'h5, cpu_ans.ctx)
        cpu(OP_SVC_RET, 12'h0);
        `CHK("ctx", 3'h2, cpu_ans.ctx)
        cpu(OP_SVC_RET, 12'h0);
        `CHK("ctx", 3'h2, cpu_ans.ctx)
        `CHK("pop_addr", 12'h0D0, cpu_ans.pop_addr)
        final_report();
    end
endmodule : nested_interrupt_context_tb
